// >>> hw/tsa_timer_unit.sv
/*
 * Sub-clock timer, lcd clock divider, counter pins, request flags and
 * count-start synchroniser / auto-stop of the first and third timers.
 * Assumes the 8-bit timers live outside and report one-cycle underflow
 * pulses on mclk; registers are reached over APB with zero wait states.
 */
// Implementation choices: the APB interface to the registers and the placing of the registers.
// Function
// - 16-bit sub-clock down counter, needs length and run
// - sub-clock counts subclock_input pulses only
// - sub-clock completion sets flag, keeps counting
// - sub-clock bit 4 feeds lcd divider
// - clearing run stops and presets all ones
// - sub-clock runs in power-down, underflow wakes
// - lcd divider 4-bit, one write loads both
// - lcd divider needs load, source, run bit
// - lcd divider divides by n+1, auto-reloads
// - lcd clock toggles per divider underflow
// - pin a: first-timer input or halved underflow
// - pwm control bit 3 puts pwm on pin b
// - external pin sources count rising edges
// - pin b as third input: driver off
// - flags set on underflow, cleared by ack/skip
// - sync enable gates counts until trigger edge
// - sync stays set until disabled or auto-stop
// - auto-stop bit 3, only with sync, stops source
module tsa_timer_unit
   import tsa_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // same-clock timer events
   input  wire logic        presc_pulse,
   input  wire logic [3:0]  timer_uf,
   input  wire logic        second_out_sel,
   input  wire logic [4:0]  int_ack,
   input  wire logic        pwm_in,
   input  wire logic        port_c_latch,
   // asynchronous pins
   input  wire logic        subclock_input,
   input  wire logic        trigger_pin_a,
   input  wire logic        trigger_pin_b,
   input  wire logic        counter_pin_a_i,
   output logic             counter_pin_a_o,
   output logic             counter_pin_a_oe,
   input  wire logic        counter_pin_b_i,
   output logic             counter_pin_b_o,
   output logic             counter_pin_b_oe,
   // results
   output logic             first_count_pulse,
   output logic             third_count_pulse,
   output logic [4:0]       timer_request_flags,
   output logic             lcd_clock,
   output logic             power_down,
   output logic             wake_pulse
);
   typedef struct packed {
      logic [2:0]  sc_ctrl;
      logic [3:0]  pin_ctrl;
      logic [3:0]  pwm_ctrl;
      logic [3:0]  t1_ctrl;
      logic [3:0]  t3_ctrl;
      logic [1:0]  ei0;
      logic [1:0]  ei1;
      logic [15:0] sc_cnt;
      logic [3:0]  lc_cnt;
      logic [3:0]  lc_rel;
      logic        lc_loaded;
      logic        lc_clk;
      logic [4:0]  flags;
      logic [1:0]  sync;
      logic        pa_tog;
      logic        pdown;
      logic        wake;
      logic [4:0]  prev;
      logic        sc_b4_prev;
      logic        t1_cnt;
      logic        t3_cnt;
      logic        pb_o;
      logic [31:0] rdata;
      logic        rerr;
   } tsa_state_t;

   tsa_state_t s_q;
   tsa_state_t s_d;

   logic [4:0]  pins_s;
   logic [4:0]  rise;
   logic [4:0]  fall;
   logic        sc_pulse;
   logic        sc_uf;
   logic [15:0] sc_mask;
   logic        lc_pulse;
   logic        lc_uf;
   logic        trig_a_edge;
   logic        trig_b_edge;
   logic        setup;
   logic        wr;
   logic        hit;
   logic [31:0] rmux;
   logic        t1_src;
   logic        t3_src;
   logic [4:0]  uf_all;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: 0 sub-clock, 1/2 triggers, 3/4 counter pins

   tsa_sync2 #(.W(5)) u_sync (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .async_i ({counter_pin_b_i, counter_pin_a_i, trigger_pin_b,
                 trigger_pin_a, subclock_input}),
      .sync_o  (pins_s)
   );

   assign rise = pins_s & ~s_q.prev;
   assign fall = ~pins_s & s_q.prev;

   ////////////////////////////////////////////////////////////////////
   // combinational helpers

   always_comb begin
      unique case (s_q.sc_ctrl[1:0])
         2'h0: sc_mask = TSA_SC_MASK0;
         2'h1: sc_mask = TSA_SC_MASK1;
         2'h2: sc_mask = TSA_SC_MASK2;
         2'h3: sc_mask = TSA_SC_MASK3;
      endcase
   end

   // only sub-clock edges advance this counter
   assign sc_pulse = rise[0] & s_q.sc_ctrl[TSA_SC_RUN];
   assign sc_uf    = sc_pulse & ((s_q.sc_cnt & sc_mask) == 16'h0000);

   // falling edge of bit 4 of the down counter is one source period
   assign lc_pulse = s_q.pin_ctrl[TSA_LC_RUN] & s_q.lc_loaded
      & (s_q.pin_ctrl[TSA_LC_SRC] ? presc_pulse
         : (s_q.sc_b4_prev & ~s_q.sc_cnt[TSA_SC_LC_BIT]));
   assign lc_uf    = lc_pulse & (s_q.lc_cnt == 4'h0);

   // interrupt-style edge judgement on the trigger pins
   assign trig_a_edge = s_q.ei0[TSA_EI_RISE] ? rise[1] : fall[1];
   assign trig_b_edge = s_q.ei1[TSA_EI_RISE] ? rise[2] : fall[2];

   always_comb begin
      unique case (s_q.t1_ctrl[1:0])
         TSA_SRC_INSTR: t1_src = 1'b1;
         TSA_SRC_PRESC: t1_src = presc_pulse;
         TSA_SRC_SUBCK: t1_src = rise[0];
         TSA_SRC_PIN:   t1_src = rise[3];
      endcase
      unique case (s_q.t3_ctrl[1:0])
         TSA_SRC_INSTR: t3_src = 1'b1;
         TSA_SRC_PRESC: t3_src = presc_pulse;
         TSA_SRC_SUBCK: t3_src = rise[0];
         TSA_SRC_PIN:   t3_src = rise[4];
      endcase
   end

   assign uf_all = {sc_uf, timer_uf};
   assign setup  = psel & ~penable;
   assign wr     = psel & penable & pwrite;
   assign hit    = (paddr <= TSA_OFS_STATUS) && (paddr[1:0] == 2'h0);

   always_comb begin
      rmux = 32'h0000_0000;
      unique case (paddr)
         TSA_OFS_SC_CTRL:  rmux[2:0]  = s_q.sc_ctrl;
         TSA_OFS_PIN_CTRL: rmux[3:0]  = s_q.pin_ctrl;
         TSA_OFS_PWM_CTRL: rmux[3:0]  = s_q.pwm_ctrl;
         TSA_OFS_T1_CTRL:  rmux[3:0]  = s_q.t1_ctrl;
         TSA_OFS_T3_CTRL:  rmux[3:0]  = s_q.t3_ctrl;
         TSA_OFS_EI0_CTRL: rmux[1:0]  = s_q.ei0;
         TSA_OFS_EI1_CTRL: rmux[1:0]  = s_q.ei1;
         TSA_OFS_FLAGS:    rmux[4:0]  = s_q.flags;
         TSA_OFS_SC_COUNT: rmux[15:0] = s_q.sc_cnt;
         TSA_OFS_STATUS:   rmux[3:0]  = {s_q.sync, s_q.lc_clk, s_q.pdown};
         default:          rmux       = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d            = s_q;
      s_d.prev       = pins_s;
      s_d.sc_b4_prev = s_q.sc_cnt[TSA_SC_LC_BIT];
      s_d.wake       = 1'b0;

      // apb: read data captured in setup, so access phase never waits
      if (setup) begin
         s_d.rdata = rmux;
         s_d.rerr  = ~hit;
      end
      if (wr && hit) begin
         unique case (paddr)
            TSA_OFS_SC_CTRL:  s_d.sc_ctrl  = pwdata[2:0];
            TSA_OFS_PIN_CTRL: s_d.pin_ctrl = pwdata[3:0];
            TSA_OFS_PWM_CTRL: s_d.pwm_ctrl = pwdata[3:0];
            TSA_OFS_T1_CTRL:  s_d.t1_ctrl  = pwdata[3:0];
            TSA_OFS_T3_CTRL:  s_d.t3_ctrl  = pwdata[3:0];
            TSA_OFS_EI0_CTRL: s_d.ei0      = pwdata[1:0];
            TSA_OFS_EI1_CTRL: s_d.ei1      = pwdata[1:0];
            TSA_OFS_STATUS:   s_d.pdown    = pwdata[TSA_ST_PDOWN];
            default:          s_d.rerr     = s_q.rerr;
         endcase
      end

      // sub-clock timer
      if (!s_q.sc_ctrl[TSA_SC_RUN]) begin
         s_d.sc_cnt = TSA_SC_PRESET;
      end else if (sc_pulse) begin
         s_d.sc_cnt = s_q.sc_cnt - 16'h0001;
      end
      // no gating by power-down; an underflow there wakes
      if (s_q.pdown && sc_uf) begin
         s_d.pdown = 1'b0;
         s_d.wake  = 1'b1;
      end

      // lcd divider: write loads counter and reload together
      if (lc_uf) begin
         s_d.lc_cnt = s_q.lc_rel;
         s_d.lc_clk = ~s_q.lc_clk;
      end else if (lc_pulse) begin
         s_d.lc_cnt = s_q.lc_cnt - 4'h1;
      end
      if (wr && paddr == TSA_OFS_LC_LOAD) begin
         s_d.lc_cnt    = pwdata[3:0];
         s_d.lc_rel    = pwdata[3:0];
         s_d.lc_loaded = 1'b1;
      end

      // halved first/second underflow for pin a
      if (second_out_sel ? timer_uf[1] : timer_uf[0]) begin
         s_d.pa_tog = ~s_q.pa_tog;
      end

      // request flags: skip-write or ack clears, a new underflow wins
      if (wr && paddr == TSA_OFS_FLAGS) begin
         s_d.flags = s_d.flags & ~pwdata[4:0];
      end
      s_d.flags = (s_d.flags & ~int_ack) | uf_all;

      // start synchronisers; trigger edge beats auto-stop
      if (s_q.t1_ctrl[TSA_T_ASTOP] && timer_uf[0]) begin
         s_d.sync[0] = 1'b0;
      end
      if (s_q.t3_ctrl[TSA_T_ASTOP] && timer_uf[2]) begin
         s_d.sync[1] = 1'b0;
      end
      if (trig_a_edge) begin
         s_d.sync[0] = 1'b1;
      end
      if (trig_b_edge) begin
         s_d.sync[1] = 1'b1;
      end
      if (!s_q.ei0[TSA_EI_SYNC]) begin
         s_d.sync[0] = 1'b0;
      end
      if (!s_q.ei1[TSA_EI_SYNC]) begin
         s_d.sync[1] = 1'b0;
      end

      // count gating: synchroniser holds the source off
      s_d.t1_cnt = s_q.t1_ctrl[TSA_T_RUN] & t1_src
         & (~s_q.ei0[TSA_EI_SYNC] | s_q.sync[0]);
      s_d.t3_cnt = s_q.t3_ctrl[TSA_T_RUN] & t3_src
         & (~s_q.ei1[TSA_EI_SYNC] | s_q.sync[1]);
      // registered pin b data; port c latch must be 0 for pwm
      s_d.pb_o = s_q.pwm_ctrl[TSA_PWM_PIN_B] ? pwm_in
         : port_c_latch;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_q         <= '0;
         s_q.sc_cnt  <= TSA_SC_PRESET;
         s_q.lc_cnt  <= TSA_LC_RST;
         s_q.lc_rel  <= TSA_LC_RST;
         s_q.t1_ctrl <= TSA_CTRL_RST;
         s_q.flags   <= TSA_FLAG_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata              = s_q.rdata;
   assign pready              = 1'b1;
   assign pslverr             = psel & penable & s_q.rerr;
   assign first_count_pulse   = s_q.t1_cnt;
   assign third_count_pulse   = s_q.t3_cnt;
   assign timer_request_flags = s_q.flags;
   assign lcd_clock           = s_q.lc_clk;
   assign power_down          = s_q.pdown;
   assign wake_pulse          = s_q.wake;
   assign counter_pin_a_o     = s_q.pa_tog;
   assign counter_pin_a_oe    = s_q.pin_ctrl[TSA_PIN_A_OUT];
   assign counter_pin_b_o     = s_q.pb_o;
   assign counter_pin_b_oe    = s_q.t3_ctrl[1:0] != TSA_SRC_PIN;

   ////////////////////////////////////////////////////////////////////
   // assertions

   a_sc_stop_preset: assert property (@(posedge mclk)
      disable iff (!rst_n) !s_q.sc_ctrl[TSA_SC_RUN]
         |=> s_q.sc_cnt == TSA_SC_PRESET)
      else $error("sub-clock not preset while stopped");
   a_sc_uf_flag: assert property (@(posedge mclk)
      disable iff (!rst_n) sc_uf |=> s_q.flags[TSA_FLAG_SC])
      else $error("sub-clock underflow did not set flag");
   a_sc_src_only: assert property (@(posedge mclk)
      disable iff (!rst_n) (s_q.sc_ctrl[TSA_SC_RUN] && !rise[0] && !wr)
         |=> $stable(s_q.sc_cnt))
      else $error("sub-clock moved without a sub-clock edge");
   a_sc_wake: assert property (@(posedge mclk)
      disable iff (!rst_n) (s_q.pdown && sc_uf)
         |=> (wake_pulse && !power_down))
      else $error("underflow in power-down did not wake");
   a_lc_reload: assert property (@(posedge mclk)
      disable iff (!rst_n) (lc_uf && !wr)
         |=> (s_q.lc_cnt == $past(s_q.lc_rel))
         && (s_q.lc_clk != $past(s_q.lc_clk)))
      else $error("lcd divider underflow missed reload or toggle");
   a_lc_unloaded: assert property (@(posedge mclk)
      disable iff (!rst_n) !s_q.lc_loaded |=> $stable(s_q.lc_clk))
      else $error("lcd clock moved before a load");
   a_pinb_hiz: assert property (@(posedge mclk)
      disable iff (!rst_n) s_q.t3_ctrl[1:0] == TSA_SRC_PIN
         |-> !counter_pin_b_oe)
      else $error("pin b driven while used as input");
   a_pinb_pwm: assert property (@(posedge mclk)
      disable iff (!rst_n) s_q.pwm_ctrl[TSA_PWM_PIN_B]
         |=> counter_pin_b_o == $past(pwm_in))
      else $error("pin b not carrying pwm");
   a_flag_set: assert property (@(posedge mclk)
      disable iff (!rst_n) timer_uf[0] |=> timer_request_flags[0])
      else $error("first timer underflow lost");
   a_sync_gate: assert property (@(posedge mclk)
      disable iff (!rst_n) (s_q.ei0[TSA_EI_SYNC] && !s_q.sync[0])
         |=> !first_count_pulse)
      else $error("count pulse passed before trigger");
   a_auto_stop: assert property (@(posedge mclk)
      disable iff (!rst_n) timer_uf[0] && s_q.t1_ctrl[TSA_T_ASTOP]
         && !trig_a_edge |=> !s_q.sync[0])
      else $error("auto-stop did not clear synchroniser");
endmodule // tsa_timer_unit

// >>> hw/tsa_pkg.sv
/*
 * Shared constants of the sub-clock timer / lcd divider / pin unit:
 * register byte offsets, field positions, reset values, length masks.
 * Assumes a 32-bit APB master and word-aligned register accesses.
 */
package tsa_pkg;
   // register byte offsets
   localparam logic [7:0] TSA_OFS_SC_CTRL  = 8'h00;
   localparam logic [7:0] TSA_OFS_PIN_CTRL = 8'h04;
   localparam logic [7:0] TSA_OFS_PWM_CTRL = 8'h08;
   localparam logic [7:0] TSA_OFS_T1_CTRL  = 8'h0C;
   localparam logic [7:0] TSA_OFS_T3_CTRL  = 8'h10;
   localparam logic [7:0] TSA_OFS_EI0_CTRL = 8'h14;
   localparam logic [7:0] TSA_OFS_EI1_CTRL = 8'h18;
   localparam logic [7:0] TSA_OFS_LC_LOAD  = 8'h1C;
   localparam logic [7:0] TSA_OFS_FLAGS    = 8'h20;
   localparam logic [7:0] TSA_OFS_SC_COUNT = 8'h24;
   localparam logic [7:0] TSA_OFS_STATUS   = 8'h28;
   // field positions
   localparam int TSA_SC_RUN     = 2;
   localparam int TSA_PIN_A_OUT  = 0;
   localparam int TSA_LC_SRC     = 2;
   localparam int TSA_LC_RUN     = 3;
   localparam int TSA_PWM_PIN_B  = 3;
   localparam int TSA_T_RUN      = 2;
   localparam int TSA_T_ASTOP    = 3;
   localparam int TSA_EI_SYNC    = 0;
   localparam int TSA_EI_RISE    = 1;
   localparam int TSA_FLAG_SC    = 4;
   localparam int TSA_SC_LC_BIT  = 4;
   localparam int TSA_ST_PDOWN   = 0;
   // timer count-source codes in bits 1:0 of first/third control
   localparam logic [1:0] TSA_SRC_INSTR = 2'h0;
   localparam logic [1:0] TSA_SRC_PRESC = 2'h1;
   localparam logic [1:0] TSA_SRC_SUBCK = 2'h2;
   localparam logic [1:0] TSA_SRC_PIN   = 2'h3;
   // sub-clock length codes: underflow every 2^8, 2^12, 2^14, 2^16 pulses
   localparam logic [15:0] TSA_SC_MASK0 = 16'h00FF;
   localparam logic [15:0] TSA_SC_MASK1 = 16'h0FFF;
   localparam logic [15:0] TSA_SC_MASK2 = 16'h3FFF;
   localparam logic [15:0] TSA_SC_MASK3 = 16'hFFFF;
   // reset values
   localparam logic [15:0] TSA_SC_PRESET = 16'hFFFF;
   localparam logic [3:0]  TSA_CTRL_RST  = 4'h0;
   localparam logic [3:0]  TSA_LC_RST    = 4'h0;
   localparam logic [4:0]  TSA_FLAG_RST  = 5'h00;
endpackage : tsa_pkg

// >>> hw/tsa_sync2.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous pin levels.
 * Assumes each bit is an independent level; no bus coherence implied.
 */
module tsa_sync2 #(
   parameter int W = 5
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // levels
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
   } tsa_sync_state_t;

   tsa_sync_state_t s_q;
   tsa_sync_state_t s_d;

   always_comb begin
      s_d     = s_q;
      s_d.ff1 = async_i;
      s_d.ff2 = s_q.ff1;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.ff2;
endmodule // tsa_sync2

// >>> tb/tsa_pins_model.sv
/*
 * Far-side model: sub-clock pulses, trigger pins, counter pin inputs.
 * Assumes the bench calls its tasks; edges are unrelated to mclk.
 */
module tsa_pins_model (
   // driven pins
   output logic subclock_input,
   output logic trigger_pin_a,
   output logic trigger_pin_b,
   output logic pin_a,
   output logic pin_b
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      {subclock_input, trigger_pin_a, trigger_pin_b, pin_a, pin_b} = 5'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // pulses wider than one mclk period so the synchroniser sees them
   task automatic sc_pulses(input int n);
      repeat (n) begin
         #41 subclock_input = 1'b1;
         #43 subclock_input = 1'b0;
      end
   endtask

   task automatic pin_edges(input logic sel, input int n);
      repeat (n) begin
         #53 if (sel) pin_b = 1'b1; else pin_a = 1'b1;
         #59 if (sel) pin_b = 1'b0; else pin_a = 1'b0;
      end
   endtask

   // a rise then a fall, so either edge polarity can start a timer
   task automatic trig(input logic sel);
      #47 if (sel) trigger_pin_b = 1'b1; else trigger_pin_a = 1'b1;
      #97 if (sel) trigger_pin_b = 1'b0; else trigger_pin_a = 1'b0;
   endtask
endmodule // tsa_pins_model

// >>> tb/test_tsa_timer_unit.sv
/*
 * Self-checking bench of the timer unit: APB tasks, pin model, pulses.
 * Assumes zero-wait APB slave and the register map of tsa_pkg.
 */
module test_tsa_timer_unit;
   timeunit 1ns;
   timeprecision 100ps;
   import tsa_pkg::*;

   logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rv;
   logic        presc_pulse, second_out_sel, pwm_in, port_c_latch, re;
   logic [3:0]  timer_uf;
   logic [4:0]  int_ack, flags;
   logic        sc_in, trg_a, trg_b, pa_m, pb_m, pa_o, pa_oe, pb_o, pb_oe;
   logic        pa_w, pb_w, cnt1, cnt3, lcd_clock, power_down, wake, l0;
   int          err_total, check_count, cnt[2], wakes;

   // wire level of the two-way counter pins
   assign pa_w = pa_oe ? pa_o : pa_m;
   assign pb_w = pb_oe ? pb_o : pb_m;

   tsa_timer_unit i_tsa_timer_unit (.mclk(mclk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .presc_pulse(presc_pulse), .timer_uf(timer_uf),
      .second_out_sel(second_out_sel), .int_ack(int_ack),
      .pwm_in(pwm_in), .port_c_latch(port_c_latch),
      .subclock_input(sc_in), .trigger_pin_a(trg_a),
      .trigger_pin_b(trg_b), .counter_pin_a_i(pa_w),
      .counter_pin_a_o(pa_o), .counter_pin_a_oe(pa_oe),
      .counter_pin_b_i(pb_w), .counter_pin_b_o(pb_o),
      .counter_pin_b_oe(pb_oe), .first_count_pulse(cnt1),
      .third_count_pulse(cnt3), .timer_request_flags(flags),
      .lcd_clock(lcd_clock), .power_down(power_down), .wake_pulse(wake));

   tsa_pins_model i_tsa_pins_model (.subclock_input(sc_in),
      .trigger_pin_a(trg_a), .trigger_pin_b(trg_b), .pin_a(pa_m),
      .pin_b(pb_m));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // counted on the falling edge, away from the register updates
   always @(negedge mclk) begin
      if (cnt1 === 1'b1) cnt[0]++;
      if (cnt3 === 1'b1) cnt[1]++;
      if (wake === 1'b1) wakes++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // no reload write is ever issued in an underflow cycle
   task automatic pulse_uf(input logic [3:0] v);
      @(posedge mclk) timer_uf <= v;
      @(posedge mclk) timer_uf <= 4'h0;
   endtask

   initial begin
      #(25 * 60000);
      err_total++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, psel, penable, pwrite, presc_pulse, second_out_sel} = 6'h00;
      {pwm_in, port_c_latch, paddr, pwdata} = 42'h0;
      timer_uf = 4'h0;
      int_ack = 5'h00;
      idle(16);
      rst_n <= 1'b1;
      rd(TSA_OFS_SC_COUNT); check("sc preset", rv, 32'h0000FFFF);
      rd(8'h2C); check("unmapped err", re, 1'b1);
      check("unmapped data", rv, 32'h0);
      // sub-clock: length code 0 underflows every 256 pulses
      wr(TSA_OFS_STATUS, 32'h1); check("pdown", power_down, 1'b1);
      wr(TSA_OFS_SC_CTRL, 32'h4);
      i_tsa_pins_model.sc_pulses(255); idle(8);
      check("sc early", flags[TSA_FLAG_SC], 1'b0);
      i_tsa_pins_model.sc_pulses(1); idle(8);
      check("sc flag", flags[TSA_FLAG_SC], 1'b1);
      check("wake", {power_down, wakes[1:0]}, 3'h1);
      rd(TSA_OFS_SC_COUNT); check("sc runs", rv, 32'h0000FEFF);
      wr(TSA_OFS_FLAGS, 32'h10); check("sc clr", flags, 5'h00);
      wr(TSA_OFS_SC_CTRL, 32'h0); i_tsa_pins_model.sc_pulses(3);
      rd(TSA_OFS_SC_COUNT); check("sc stop", rv, 32'h0000FFFF);
      // lcd divider from prescaler, n = 2: toggles every 3rd pulse
      wr(TSA_OFS_LC_LOAD, 32'h2);
      rd(TSA_OFS_LC_LOAD); check("lc unread", rv, 32'h0);
      wr(TSA_OFS_PIN_CTRL, 32'h4); wr(TSA_OFS_PIN_CTRL, 32'hC);
      l0 = lcd_clock;
      for (int i = 1; i <= 6; i++) begin
         @(posedge mclk) presc_pulse <= 1'b1;
         @(posedge mclk) presc_pulse <= 1'b0;
         idle(4);
         check("lcd div", lcd_clock, l0 ^ ((i / 3) % 2));
      end
      // n = 0 on sub-clock bit 4: one transition per 32 pulses
      wr(TSA_OFS_PIN_CTRL, 32'h0);
      wr(TSA_OFS_LC_LOAD, 32'h0); wr(TSA_OFS_PIN_CTRL, 32'h8);
      l0 = lcd_clock;
      wr(TSA_OFS_SC_CTRL, 32'h4);
      i_tsa_pins_model.sc_pulses(32); idle(8);
      check("lcd bit4", lcd_clock, !l0);
      wr(TSA_OFS_SC_CTRL, 32'h0);
      // pin a as halved underflow output, flags set and cleared
      wr(TSA_OFS_PIN_CTRL, 32'h1); check("pa oe", pa_oe, 1'b1);
      l0 = pa_o;
      pulse_uf(4'h2); idle(3); check("pa t2 off", pa_o, l0);
      pulse_uf(4'h1); idle(3); check("pa t1", pa_o, !l0);
      check("flags set", flags[1:0], 2'h3);
      @(posedge mclk) int_ack <= 5'h01;
      @(posedge mclk) int_ack <= 5'h00;
      idle(2); check("ack clr", flags[1:0], 2'h2);
      wr(TSA_OFS_FLAGS, 32'h2); check("skip clr", flags[1:0], 2'h0);
      @(posedge mclk) second_out_sel <= 1'b1;
      pulse_uf(4'h2); idle(3); check("pa t2", pa_o, l0);
      wr(TSA_OFS_PIN_CTRL, 32'h0); check("pa in", pa_oe, 1'b0);
      // pin b: pwm or port latch, released when used as input
      @(posedge mclk) port_c_latch <= 1'b0;
      wr(TSA_OFS_PWM_CTRL, 32'h8);
      // pwm_in stands for a fourth timer with high reload >= 1
      @(posedge mclk) pwm_in <= 1'b1;
      idle(2); check("pb pwm1", pb_o, 1'b1);
      pwm_in <= 1'b0; idle(2); check("pb pwm0", pb_o, 1'b0);
      wr(TSA_OFS_PWM_CTRL, 32'h0);
      @(posedge mclk) port_c_latch <= 1'b1;
      pwm_in <= 1'b1; idle(2); check("pb latch", pb_o, 1'b1);
      port_c_latch <= 1'b0; idle(2); check("pb latch0", pb_o, 1'b0);
      wr(TSA_OFS_T3_CTRL, 32'h3); check("pb hiz", pb_oe, 1'b0);
      // rising edges of both counter pins
      wr(TSA_OFS_T1_CTRL, 32'h7); wr(TSA_OFS_T3_CTRL, 32'h7);
      for (int t = 0; t < 2; t++) begin
         cnt[t] = 0;
         i_tsa_pins_model.pin_edges(t[0], 5); idle(6);
         check("pin edges", cnt[t], 5);
      end
      // start sync and auto-stop, first then third timer
      for (int t = 0; t < 2; t++) begin
         wr(t ? TSA_OFS_T3_CTRL : TSA_OFS_T1_CTRL, 32'h0);
         // third timer is started by a falling trigger edge
         wr(t ? TSA_OFS_EI1_CTRL : TSA_OFS_EI0_CTRL, t ? 32'h1 : 32'h3);
         wr(t ? TSA_OFS_T3_CTRL : TSA_OFS_T1_CTRL, 32'hC);
         cnt[t] = 0; idle(20); check("gated", cnt[t], 0);
         i_tsa_pins_model.trig(t[0]); idle(10);
         check("started", cnt[t] > 5, 1'b1);
         pulse_uf(t ? 4'h4 : 4'h1); idle(4);
         cnt[t] = 0; idle(10); check("auto stop", cnt[t], 0);
         wr(t ? TSA_OFS_T3_CTRL : TSA_OFS_T1_CTRL, 32'h4);
         i_tsa_pins_model.trig(t[0]); idle(6);
         pulse_uf(t ? 4'h4 : 4'h1); idle(4);
         cnt[t] = 0; idle(6); check("held", cnt[t] > 3, 1'b1);
         wr(t ? TSA_OFS_EI1_CTRL : TSA_OFS_EI0_CTRL, 32'h0);
         wr(t ? TSA_OFS_T3_CTRL : TSA_OFS_T1_CTRL, 32'h0);
      end
      report_and_stop();
   end
endmodule // test_tsa_timer_unit
